// File: hdl/apm_pkg.sv
// Purpose: Shared constants for the accelerometer power-mode controller.
// Assumes: 20 MHz sampling timebase, host access over a 4-wire serial port.
// Notes:   Field positions, offsets, reset values and timing live here only.
//
// Contract
// - After power-up the device sits in standby with every sensing function off.
// - Run bit 3 of power control (0x2D) enters measurement; clearing returns standby.
// - Every register is readable and writable while in standby.
// - Standby makes no measurements and keeps all sensor functions disabled.
// - Measurement mode makes all sensing functions operational.
// - Entering standby leaves stored sample FIFO entries intact and readable.
// - Low-power bit 4 of 0x2C lowers internal sampling, output rate unchanged.
// - Auto-sleep plus link bits sleep on inactivity set by 0x25 and 0x26.
// - While asleep, sampling runs at a reduced rate below 8 Hz.

package apm_pkg;

    // ==========================================================
    // Register map
    localparam logic [5:0] ADDR_INACT_THR   = 6'h25;
    localparam logic [5:0] ADDR_INACT_TIME  = 6'h26;
    localparam logic [5:0] ADDR_RATE_SEL    = 6'h2C;
    localparam logic [5:0] ADDR_POWER_CONTROL   = 6'h2D;

    localparam logic [7:0] RST_INACT_THR    = 8'h00;
    localparam logic [7:0] RST_INACT_TIME   = 8'h00;
    localparam logic [7:0] RST_RATE_SEL     = 8'h0A;
    localparam logic [7:0] RST_POWER_CONTROL    = 8'h00;

    // ==========================================================
    // Field positions
    localparam int         PWR_RUN_BIT      = 3;
    localparam int         PWR_AUTOSLP_BIT  = 4;
    localparam int         PWR_LINK_BIT     = 5;
    localparam int         RATE_LOWPWR_BIT  = 4;
    localparam int         RATE_CODE_MSB    = 3;
    localparam int         HDR_RW_BIT       = 7;
    localparam int         HDR_MB_BIT       = 6;
    localparam logic [2:0] BYTE_LAST_BIT    = 3'h7;
    localparam logic [2:0] BYTE_FIRST_BIT   = 3'h0;

    // ==========================================================
    // Rate codes
    localparam logic [3:0] RATE_CODE_MAX    = 4'hF;
    localparam logic [3:0] RATE_CODE_MIN    = 4'h6;
    localparam logic [3:0] RATE_CODE_SLEEP  = 4'h6;

    // ==========================================================
    // Timing
    localparam int         CLK_HZ           = 20_000_000;
    localparam int         ODR_MAX_HZ       = 3200;
    localparam int         ODR_BASE_CYCLES  = CLK_HZ / ODR_MAX_HZ;
    localparam int         INACT_UNIT_S     = 1;
    localparam int         INACT_UNIT_CYC   = CLK_HZ * INACT_UNIT_S;

    // ==========================================================
    // Power modes
    typedef enum logic [1:0] {
        APM_STANDBY = 2'b00,
        APM_MEASURE = 2'b01,
        APM_SLEEP   = 2'b10
    } apm_mode_t;

endpackage : apm_pkg

// File: hdl/apm_power_ctrl.sv
// Purpose: Power-mode controller with its serial register port.
// Assumes: Serial port is 4-wire, clock idles high, data sampled on rising edge.
// Notes:   Registers live in the serial clock domain and are copied to the
//          timebase domain by a toggle handshake after every write.

`timescale 1ns/1ps
`default_nettype none

module apm_power_ctrl #(
    parameter int ODR_BASE_CYCLES = apm_pkg::ODR_BASE_CYCLES,
    parameter int INACT_UNIT_CYC  = apm_pkg::INACT_UNIT_CYC
) (
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    input  wire logic       ce_in,
    input  wire logic       sclk_in,
    input  wire logic       cs_n_in,
    input  wire logic       sdi_in,
    output logic            sdo_out,
    output logic            sdo_oe_out,
    input  wire logic [7:0] accel_mag_in,
    output logic      [1:0] mode_out,
    output logic            sensors_on_out,
    output logic            conv_strobe_out,
    output logic            sample_strobe_out
);

    // ==========================================================
    // Serial clock domain: frame state

    logic       frame_rst;
    logic [2:0] bit_cnt;
    logic       in_data;
    logic       is_read;
    logic       burst;
    logic [5:0] addr;
    logic [6:0] rx_sh;
    logic [7:0] rx_byte;
    logic [7:0] rdata;
    logic [7:0] tx_sh;
    logic [7:0] inactivity_threshold;
    logic [7:0] inactivity_time;
    logic [7:0] rate_and_power_select;
    logic [7:0] power_control;
    logic       wr_tog;

    // The frame ends by chip select alone; the serial clock may stop any time.
    assign frame_rst = rst_in | cs_n_in;
    assign rx_byte   = {rx_sh, sdi_in};

    // Address decode for reads; unmapped addresses answer zero.
    function automatic logic [7:0] reg_read(input logic [5:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == apm_pkg::ADDR_INACT_THR) begin
            v = inactivity_threshold;
        end else if (a == apm_pkg::ADDR_INACT_TIME) begin
            v = inactivity_time;
        end else if (a == apm_pkg::ADDR_RATE_SEL) begin
            v = rate_and_power_select;
        end else if (a == apm_pkg::ADDR_POWER_CONTROL) begin
            v = power_control;
        end
        return v;
    endfunction : reg_read

    // Header byte, then data bytes; burst mode advances the address per byte.
    always_ff @(posedge sclk_in or posedge frame_rst) begin
        if (frame_rst) begin
            bit_cnt <= apm_pkg::BYTE_FIRST_BIT;
            in_data <= 1'b0;
            is_read <= 1'b0;
            burst   <= 1'b0;
            addr    <= 6'h00;
            rx_sh   <= 7'h00;
            rdata   <= 8'h00;
        end else begin
            rx_sh   <= rx_byte[6:0];
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == apm_pkg::BYTE_LAST_BIT) begin
                if (!in_data) begin
                    in_data <= 1'b1;
                    is_read <= rx_byte[apm_pkg::HDR_RW_BIT];
                    burst   <= rx_byte[apm_pkg::HDR_MB_BIT];
                    addr    <= rx_byte[5:0];
                    rdata   <= reg_read(rx_byte[5:0]);
                end else if (burst) begin
                    addr    <= addr + 6'h01;
                    rdata   <= reg_read(addr + 6'h01);
                end
            end
        end
    end

    // Registers accept writes in any mode, standby included.
    // They hold still between writes, which makes the bulk copy below safe.
    always_ff @(posedge sclk_in or posedge rst_in) begin
        if (rst_in) begin
            inactivity_threshold  <= apm_pkg::RST_INACT_THR;
            inactivity_time       <= apm_pkg::RST_INACT_TIME;
            rate_and_power_select <= apm_pkg::RST_RATE_SEL;
            power_control         <= apm_pkg::RST_POWER_CONTROL;
            wr_tog                <= 1'b0;
        end else if (!cs_n_in && in_data && !is_read
                     && bit_cnt == apm_pkg::BYTE_LAST_BIT) begin
            wr_tog <= ~wr_tog;
            if (addr == apm_pkg::ADDR_INACT_THR) begin
                inactivity_threshold <= rx_byte;
            end else if (addr == apm_pkg::ADDR_INACT_TIME) begin
                inactivity_time <= rx_byte;
            end else if (addr == apm_pkg::ADDR_RATE_SEL) begin
                rate_and_power_select <= rx_byte;
            end else if (addr == apm_pkg::ADDR_POWER_CONTROL) begin
                power_control <= rx_byte;
            end
        end
    end

    // Read data shifts out on falling edges, most significant bit first.
    always_ff @(negedge sclk_in or posedge frame_rst) begin
        if (frame_rst) begin
            tx_sh      <= 8'h00;
            sdo_out    <= 1'b0;
            sdo_oe_out <= 1'b0;
        end else if (in_data && is_read) begin
            sdo_oe_out <= 1'b1;
            if (bit_cnt == apm_pkg::BYTE_FIRST_BIT) begin
                sdo_out <= rdata[7];
                tx_sh   <= {rdata[6:0], 1'b0};
            end else begin
                sdo_out <= tx_sh[7];
                tx_sh   <= {tx_sh[6:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // Timebase domain: register copy

    logic [2:0] tog_sync;
    logic       wr_seen;
    logic [7:0] thr_q;
    logic [7:0] time_q;
    logic [7:0] rate_q;
    logic [7:0] pwr_q;

    // Toggle synchroniser; only the second and third stages meet logic besides the chain.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tog_sync <= 3'h0;
        end else if (ce_in) begin
            tog_sync <= {tog_sync[1:0], wr_tog};
        end
    end

    assign wr_seen = tog_sync[1] ^ tog_sync[2];

    // Copy all four registers once the write toggle has settled.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            thr_q  <= apm_pkg::RST_INACT_THR;
            time_q <= apm_pkg::RST_INACT_TIME;
            rate_q <= apm_pkg::RST_RATE_SEL;
            pwr_q  <= apm_pkg::RST_POWER_CONTROL;
        end else if (ce_in && wr_seen) begin
            thr_q  <= inactivity_threshold;
            time_q <= inactivity_time;
            rate_q <= rate_and_power_select;
            pwr_q  <= power_control;
        end
    end

    // ==========================================================
    // Timebase domain: sample pacing

    apm_pkg::apm_mode_t mode;
    apm_pkg::apm_mode_t next_mode;
    logic [3:0]  code_sel;
    logic [3:0]  eff_code;
    logic [21:0] period;
    logic [21:0] odr_cnt;
    logic        odr_end;
    logic        odr_half;
    logic        active_hit;

    assign code_sel = rate_q[apm_pkg::RATE_CODE_MSB:0];

    // Asleep, the rate code is overridden by the slow sleep rate.
    // Codes under the slowest documented rate are clamped to it.
    always_comb begin
        if (mode == apm_pkg::APM_SLEEP) begin
            eff_code = apm_pkg::RATE_CODE_SLEEP;
        end else if (code_sel < apm_pkg::RATE_CODE_MIN) begin
            eff_code = apm_pkg::RATE_CODE_MIN;
        end else begin
            eff_code = code_sel;
        end
    end

    // Each step down in code doubles the period.
    assign period   = 22'(ODR_BASE_CYCLES) << (apm_pkg::RATE_CODE_MAX - eff_code);
    // A compare by magnitude stops a long sleep count from running on
    // when a shorter measuring period takes over in mid-count.
    assign odr_end  = (odr_cnt >= period - 22'h1);
    assign odr_half = (odr_cnt == (period >> 1) - 22'h1);

    // The pacing counter is parked at zero in standby so nothing samples.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            odr_cnt <= 22'h0;
        end else if (ce_in) begin
            if (mode == apm_pkg::APM_STANDBY || odr_end) begin
                odr_cnt <= 22'h0;
            end else begin
                odr_cnt <= odr_cnt + 22'h1;
            end
        end
    end

    // Normal mode converts twice per output sample; low power converts once,
    // saving power at the cost of a little noise.
    // The output strobe also writes the FIFO; standby never flushes it.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            conv_strobe_out   <= 1'b0;
            sample_strobe_out <= 1'b0;
        end else if (ce_in) begin
            // The next mode is used so that no strobe leaves with standby on mode_out.
            if (next_mode == apm_pkg::APM_STANDBY) begin
                conv_strobe_out   <= 1'b0;
                sample_strobe_out <= 1'b0;
            end else begin
                conv_strobe_out   <= odr_end
                    || (odr_half && !rate_q[apm_pkg::RATE_LOWPWR_BIT]);
                sample_strobe_out <= odr_end;
            end
        end
    end

    // ==========================================================
    // Timebase domain: inactivity timing

    logic [24:0] unit_cnt;
    logic [7:0]  inact_units;
    logic        sleep_armed;

    assign active_hit  = odr_end && (accel_mag_in > thr_q);
    assign sleep_armed = pwr_q[apm_pkg::PWR_AUTOSLP_BIT] && pwr_q[apm_pkg::PWR_LINK_BIT];

    // Whole time units of quiet since the last above-threshold sample.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            unit_cnt    <= 25'h0;
            inact_units <= 8'h00;
        end else if (ce_in) begin
            if (mode != apm_pkg::APM_MEASURE || active_hit) begin
                unit_cnt    <= 25'h0;
                inact_units <= 8'h00;
            end else if (unit_cnt == 25'(INACT_UNIT_CYC - 1)) begin
                unit_cnt <= 25'h0;
                if (inact_units != 8'hFF) begin
                    inact_units <= inact_units + 8'h01;
                end
            end else begin
                unit_cnt <= unit_cnt + 25'h1;
            end
        end
    end

    // ==========================================================
    // Timebase domain: mode machine

    // Run bit rules every mode; sleep needs both arming bits.
    always_comb begin
        next_mode = mode;
        case (mode)
            apm_pkg::APM_STANDBY: begin
                if (pwr_q[apm_pkg::PWR_RUN_BIT]) begin
                    next_mode = apm_pkg::APM_MEASURE;
                end
            end
            apm_pkg::APM_MEASURE: begin
                if (!pwr_q[apm_pkg::PWR_RUN_BIT]) begin
                    next_mode = apm_pkg::APM_STANDBY;
                end else if (sleep_armed && inact_units >= time_q) begin
                    next_mode = apm_pkg::APM_SLEEP;
                end
            end
            apm_pkg::APM_SLEEP: begin
                if (!pwr_q[apm_pkg::PWR_RUN_BIT]) begin
                    next_mode = apm_pkg::APM_STANDBY;
                end else if (!sleep_armed || active_hit) begin
                    next_mode = apm_pkg::APM_MEASURE;
                end
            end
            default: begin
                next_mode = apm_pkg::APM_STANDBY;
            end
        endcase
    end

    // Mode register and its flopped views; reset lands in standby.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mode           <= apm_pkg::APM_STANDBY;
            mode_out       <= apm_pkg::APM_STANDBY;
            sensors_on_out <= 1'b0;
        end else if (ce_in) begin
            mode           <= next_mode;
            mode_out       <= next_mode;
            sensors_on_out <= (next_mode != apm_pkg::APM_STANDBY);
        end
    end

endmodule : apm_power_ctrl

`default_nettype wire

// File: verification/accel_power_mode_control_test.sv
// Purpose: Self-checking bench for the power-mode controller.
// Assumes: Host model drives the serial port; ce_in is held high.
// Notes:   Short rate and inactivity parameters keep the run brief.
`timescale 1ns/1ps
`default_nettype none
module accel_power_mode_control_test;
    localparam int ODR = 8;
    logic       clk_in = 1'b0;
    logic       rst_in = 1'b1;
    logic [7:0] mag    = 8'h00;
    wire        sclk, cs_n, sdi, sdo, sdo_oe, conv, smp, son;
    wire  [1:0] mode;
    int         error_cnt = 0;
    int         n_checks  = 0;
    int         cyc       = 0;
    int         code, n;
    logic       lp;
    logic [7:0] mdl [logic [5:0]];

    // ==========
    // Clock and hang guard; a stuck wait ends the run as a failure.
    always #25 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 90000) begin
            error_cnt++;
            summarize();
        end
    end

    apm_power_ctrl #(.ODR_BASE_CYCLES(ODR), .INACT_UNIT_CYC(16)) u_apm_power_ctrl (
        .clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .sclk_in(sclk), .cs_n_in(cs_n),
        .sdi_in(sdi), .sdo_out(sdo), .sdo_oe_out(sdo_oe), .accel_mag_in(mag),
        .mode_out(mode), .sensors_on_out(son), .conv_strobe_out(conv),
        .sample_strobe_out(smp));
    apm_host_model u_apm_host_model (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
        .sdo_in(sdo), .sdo_oe_in(sdo_oe));

    // ==========
    // Shared helpers.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic summarize();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize

    // Writes land in the model only where a register exists.
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_apm_host_model.xfer({2'b00, a}, d, r);
        if (mdl.exists(a)) mdl[a] = d;
        @(posedge clk_in);
        #1;
    endtask : wr

    task automatic rdchk(input logic [5:0] a);
        logic [7:0] r;
        u_apm_host_model.xfer({2'b10, a}, 8'h00, r);
        chk(r, mdl.exists(a) ? mdl[a] : 8'h00);
        @(posedge clk_in);
        #1;
    endtask : rdchk

    task automatic wmode(input logic [1:0] m, input int lim);
        int c;
        c = 0;
        while (mode !== m && c < lim) begin @(posedge clk_in); #1; c++; end
        chk(mode, m);
    endtask : wmode

    // Skips to a sample, then times one full period and its conversions.
    task automatic period(input int per, input int nc);
        int c;
        int k;
        c = 0;
        k = 0;
        while (smp !== 1'b1 && c < 9000) begin @(posedge clk_in); #1; c++; end
        c = 0;
        do begin
            @(posedge clk_in);
            #1;
            c++;
            k += int'(conv === 1'b1);
        end while (smp !== 1'b1 && c < 9000);
        chk(16'(c), 16'(per));
        chk(16'(k), 16'(nc));
    endtask : period

    // ==========
    // Main sequence.
    initial begin
        void'($urandom(43681));
        repeat (3) @(posedge clk_in);
        #1 rst_in = 1'b0;
        mdl[6'h25] = 8'h00;
        mdl[6'h26] = 8'h00;
        mdl[6'h2C] = 8'h0A;
        mdl[6'h2D] = 8'h00;
        chk(mode, 2'b00);
        chk(son, 1'b0);
        foreach (mdl[a]) rdchk(a);
        rdchk(6'h00);
        $display("test reset done");
        // Configure everything in standby, run and sleep bits kept clear.
        wr(6'h25, 8'($urandom));
        wr(6'h26, 8'($urandom));
        wr(6'h2C, 8'($urandom));
        wr(6'h2D, 8'($urandom) & 8'hC7);
        wr(6'h00, 8'h5A);
        foreach (mdl[a]) rdchk(a);
        rdchk(6'h00);
        chk(mode, 2'b00);
        $display("test config done");
        // Rate codes 15 down to 6, then low power on codes 7 to 12 only.
        for (int k = 0; k < 16; k++) begin
            code = (k < 10) ? 15 - k : k - 3;
            lp = (k >= 10);
            wr(6'h2D, 8'h00);
            wr(6'h2C, {3'b000, lp, 4'(code)});
            wr(6'h2D, 8'h08);
            wmode(2'b01, 20);
            chk(son, 1'b1);
            period(ODR << (15 - code), lp ? 1 : 2);
        end
        $display("test rates done");
        wr(6'h2D, 8'h00);
        wmode(2'b00, 20);
        n = 0;
        repeat (200) begin @(posedge clk_in); #1; n += int'(smp === 1'b1 || conv === 1'b1); end
        chk(16'(n), 16'h0000);
        chk(son, 1'b0);
        rdchk(6'h2C);
        $display("test standby done");
        // Quiet input arms sleep; a strong one wakes the device.
        mag = 8'($urandom_range(0, 63));
        wr(6'h25, 8'h40);
        wr(6'h26, 8'h01);
        wr(6'h2C, 8'h0F);
        wr(6'h2D, 8'h38);
        wmode(2'b10, 3000);
        period(ODR << 9, 2);
        mag = 8'hFF;
        wmode(2'b01, 9000);
        $display("test sleep done");
        summarize();
    end
endmodule : accel_power_mode_control_test
`default_nettype wire

// File: verification/apm_host_model.sv
// Purpose: Host master model for the serial register port.
// Assumes: Clock idles high; the device samples data on rising edges.
// Notes:   The serial clock runs only inside frames, 15 ns a bit.
`timescale 1ns/1ps
`default_nettype none
module apm_host_model (
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      sdi_out,
    input  wire logic sdo_in,
    input  wire logic sdo_oe_in
);
    // ==========
    // Idle bus: clock parked high, device deselected.
    initial begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        sdi_out  = 1'b0;
    end

    // ==========
    // One frame of header and one data byte; sdi moves on falling edges.
    // Read data is taken at rising edges, where it has stood half a bit.
    task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] sh;
        sh = {hdr, wd};
        rd = 8'h00;
        cs_n_out = 1'b0;
        #10;
        for (int i = 15; i >= 0; i--) begin
            sclk_out = 1'b0;
            sdi_out  = sh[i];
            #7.5;
            sclk_out = 1'b1;
            if (i < 8) rd[i] = sdo_oe_in ? sdo_in : 1'bx;
            #7.5;
        end
        #5;
        cs_n_out = 1'b1;
        // A stale bit must not look like a held value.
        sdi_out  = ~sdi_out;
        #300;
    endtask : xfer
endmodule : apm_host_model
`default_nettype wire

// File: verification/apm_power_ctrl_asserts.sv
// Purpose: Concurrent checks on the power-mode controller ports.
// Assumes: Bound to every instance of apm_power_ctrl.
// Notes:   The sleep-rate check needs the instance's ODR_BASE_CYCLES.
`timescale 1ns/1ps
`default_nettype none
module apm_power_ctrl_asserts #(
    parameter int ODR_BASE_CYCLES = apm_pkg::ODR_BASE_CYCLES,
    parameter int INACT_UNIT_CYC  = apm_pkg::INACT_UNIT_CYC
) (
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic       ce_in,
    input wire logic       sclk_in,
    input wire logic       cs_n_in,
    input wire logic       sdi_in,
    input wire logic       sdo_out,
    input wire logic       sdo_oe_out,
    input wire logic [7:0] accel_mag_in,
    input wire logic [1:0] mode_out,
    input wire logic       sensors_on_out,
    input wire logic       conv_strobe_out,
    input wire logic       sample_strobe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    // ==========
    // Cycles since the last sample; a mode change voids the count,
    // since the first period after a change may be partial.
    int         gap;
    logic       slp_ok;
    logic [1:0] prev_mode;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            gap       <= 0;
            slp_ok    <= 1'b0;
            prev_mode <= 2'b00;
        end else begin
            prev_mode <= mode_out;
            if (mode_out != prev_mode) begin
                gap    <= 0;
                slp_ok <= 1'b0;
            end else if (sample_strobe_out) begin
                gap    <= 0;
                slp_ok <= (mode_out == 2'b10);
            end else begin
                gap <= gap + 1;
            end
        end
    end

    // ==========
    // Mode, sensing and strobe relations.
    a_reset_standby: assert property ($fell(rst_in) |-> mode_out == 2'b00 && !sensors_on_out)
        else $error("not in standby after reset");
    a_standby_quiet: assert property (mode_out == 2'b00 |->
        !sensors_on_out && !sample_strobe_out && !conv_strobe_out) else $error("standby active");
    a_active_sensing: assert property (mode_out != 2'b00 |-> sensors_on_out)
        else $error("sensing off while measuring");
    a_mode_legal: assert property (mode_out != 2'b11) else $error("illegal mode");
    a_sample_conv: assert property (sample_strobe_out |-> conv_strobe_out)
        else $error("sample without conversion");
    a_strobe_pulse: assert property (sample_strobe_out |=> !sample_strobe_out)
        else $error("sample strobe too long");
    a_oe_idle: assert property (cs_n_in [*2] |-> !sdo_oe_out)
        else $error("sdo driven while deselected");
    a_sleep_rate: assert property (sample_strobe_out && slp_ok && mode_out == 2'b10
        |-> gap == (ODR_BASE_CYCLES << 9) - 1) else $error("sleep rate wrong");
endmodule : apm_power_ctrl_asserts

bind apm_power_ctrl apm_power_ctrl_asserts #(
    .ODR_BASE_CYCLES(ODR_BASE_CYCLES), .INACT_UNIT_CYC(INACT_UNIT_CYC)
) u_apm_power_ctrl_asserts (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .sclk_in(sclk_in),
    .cs_n_in(cs_n_in), .sdi_in(sdi_in), .sdo_out(sdo_out), .sdo_oe_out(sdo_oe_out),
    .accel_mag_in(accel_mag_in), .mode_out(mode_out), .sensors_on_out(sensors_on_out),
    .conv_strobe_out(conv_strobe_out), .sample_strobe_out(sample_strobe_out)
);
`default_nettype wire
